//--- verilog/osr_pkg.sv
package osr_pkg;
    // Register addresses
    localparam logic [5:0] OSR_ADDR_CTRL = 6'h0f;
    localparam logic [5:0] OSR_ADDR_RSV_A = 6'h10;
    localparam logic [5:0] OSR_ADDR_RSV_B = 6'h11;
    localparam logic [5:0] OSR_ADDR_READBACK = 6'h12;
    localparam logic [5:0] OSR_ADDR_SELFTEST = 6'h13;
    // Widths
    localparam int OSR_DATA_W = 24;
    localparam int OSR_CTRL_W = 10;
    localparam int OSR_SIG_W = 16;
    // Control field positions
    localparam int OSR_SEL_LSB = 0;
    localparam int OSR_SEL_MSB = 4;
    localparam int OSR_FORCE_BIT = 5;
    localparam int OSR_HOLD_BIT = 6;
    localparam int OSR_KEEP_BIT = 7;
    localparam int OSR_PU_OFF_BIT = 8;
    localparam int OSR_PD_OFF_BIT = 9;
    // Readback and self-test field positions
    localparam int OSR_RB_GPO_BIT = 0;
    localparam int OSR_RB_LOCK_BIT = 1;
    localparam int OSR_ST_BUSY_BIT = 16;
    // Reset values
    localparam logic [9:0] OSR_CTRL_RST = 10'h001;
    localparam logic [23:0] OSR_RD_RST = 24'h000000;
    // Source select codes with special meaning
    localparam logic [4:0] OSR_SEL_FORCE = 5'h00;
    localparam logic [4:0] OSR_SEL_LOCK = 5'h01;
    localparam logic [4:0] OSR_SEL_RSV7 = 5'h07;
    localparam logic [4:0] OSR_SEL_UNUSED_LO = 5'h1a;
    localparam logic [4:0] OSR_SEL_UNUSED_HI = 5'h1d;
    localparam logic [4:0] OSR_SEL_BUF_EN = 5'h1e;
    localparam logic [4:0] OSR_SEL_SOFT_RST = 5'h1f;
endpackage

//--- verilog/osr_output_select.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: The 5-bit source select in control bits 4:0 picks the signal sent to data out, reset code 1.
// RULE_02: Codes 1, 2 and 3 give lock indicator, lock detect trigger and lock detect window.
// RULE_03: Code 4 gives ring oscillator test, codes 5 and 6 the cycle slip guard pull-up, 7 is reserved.
// RULE_04: Codes 8 to 12 give ref buffer, ref divider, divider, modulator clock and auxiliary clock.
// RULE_05: Codes 13-15 give aux serial clock, enable, data; 16-17 phase pulses; 18-19 modulator clocks.
// RULE_06: Codes 20 to 25 give the write strobes, latch enable, divider sync reset and seed load.
// RULE_07: Codes 26 to 29 are unused, 30 gives the output buffer enable, 31 the software reset.
// RULE_08: Code 0 drives data out with the forced value bit 5, reset 0.
// RULE_09: Bit 6 stops the automatic sharing of data out with the selected signal, reset 0.
// RULE_10: Bit 7 keeps the data out driver on even when the serial interface would turn it off.
// RULE_11: Addresses 10h and 11h are reserved read-only and read as zero.
// RULE_12: Address 12h reads the output state in bit 0 and the lock indicator in bit 1, reset 0.
// RULE_13: The 16-bit self-test signature reads in bits 15:0 of 13h, reset 0.
// RULE_14: Bit 16 of 13h is the self-test busy flag, reset 0.
// RULE_15: Bits 8 and 9 switch off the pull-up and pull-down halves, both off leaves the pin undriven.
module osr_output_select
    import osr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register access from the serial interface
    input wire logic reg_wr_en,
    input wire logic [5:0] reg_wr_addr,
    input wire logic [23:0] reg_wr_data,
    input wire logic [5:0] reg_rd_addr,
    output logic [23:0] reg_rd_data,
    // Serial interface read-out path
    input wire logic spi_read_active,
    input wire logic spi_read_data,
    // Selectable internal signals, asynchronous to clk
    input wire logic lock_detect,
    input wire logic lock_detect_trigger,
    input wire logic lock_detect_window,
    input wire logic ring_osc_test,
    input wire logic cycle_slip_guard_pullup,
    input wire logic ref_buffer_out,
    input wire logic ref_divider_out,
    input wire logic divider_out,
    input wire logic sigma_delta_modulator_clk,
    input wire logic aux_clk,
    input wire logic aux_spi_clk,
    input wire logic aux_spi_enable,
    input wire logic aux_spi_data_out,
    input wire logic phase_detector_down_pulse,
    input wire logic phase_detector_up_pulse,
    input wire logic sigma_delta_modulator_clk_delay,
    input wire logic sigma_delta_modulator_core_clk,
    input wire logic auto_strobe_int_write,
    input wire logic auto_strobe_frac_write,
    input wire logic auto_strobe_aux_spi,
    input wire logic spi_latch_enable,
    input wire logic divider_sync_reset,
    input wire logic seed_load_strobe,
    input wire logic software_reset_n,
    // Self-test engine, same clock
    input wire logic [15:0] self_test_signature,
    input wire logic self_test_running,
    // Data out pin driver
    output logic sdo_out,
    output logic sdo_oe,
    output logic sdo_pullup_on,
    output logic sdo_pulldown_on
);

    logic [9:0] ctrl;
    logic [31:0] src_raw;
    logic [31:0] src_meta;
    logic [31:0] src_sync;
    logic gpo_state;
    logic next_gpo;
    logic [15:0] sig_q;
    logic busy_q;
    logic [4:0] sel;
    logic force_val;
    logic hold_off_auto_lock_mux;
    logic keep_driver;
    logic pullup_transistor_off;
    logic pulldown_transistor_off;
    logic next_oe;
    logic next_out;

    assign sel = ctrl[OSR_SEL_MSB:OSR_SEL_LSB];
    assign force_val = ctrl[OSR_FORCE_BIT];
    assign hold_off_auto_lock_mux = ctrl[OSR_HOLD_BIT];
    assign keep_driver = ctrl[OSR_KEEP_BIT];
    assign pullup_transistor_off = ctrl[OSR_PU_OFF_BIT];
    assign pulldown_transistor_off = ctrl[OSR_PD_OFF_BIT];

    // Source vector indexed by select code; unused codes tie low
    // RULE_02: lock detect sources
    assign src_raw[0] = 1'b0;
    assign src_raw[1] = lock_detect;
    assign src_raw[2] = lock_detect_trigger;
    assign src_raw[3] = lock_detect_window;
    // RULE_03: test and pull-up sources
    assign src_raw[4] = ring_osc_test;
    assign src_raw[5] = cycle_slip_guard_pullup;
    assign src_raw[6] = cycle_slip_guard_pullup;
    assign src_raw[7] = 1'b0;
    // RULE_04: clock path sources
    assign src_raw[8] = ref_buffer_out;
    assign src_raw[9] = ref_divider_out;
    assign src_raw[10] = divider_out;
    assign src_raw[11] = sigma_delta_modulator_clk;
    assign src_raw[12] = aux_clk;
    // RULE_05: aux serial, phase and modulator sources
    assign src_raw[13] = aux_spi_clk;
    assign src_raw[14] = aux_spi_enable;
    assign src_raw[15] = aux_spi_data_out;
    assign src_raw[16] = phase_detector_down_pulse;
    assign src_raw[17] = phase_detector_up_pulse;
    assign src_raw[18] = sigma_delta_modulator_clk_delay;
    assign src_raw[19] = sigma_delta_modulator_core_clk;
    // RULE_06: strobe sources
    assign src_raw[20] = auto_strobe_int_write;
    assign src_raw[21] = auto_strobe_frac_write;
    assign src_raw[22] = auto_strobe_aux_spi;
    assign src_raw[23] = spi_latch_enable;
    assign src_raw[24] = divider_sync_reset;
    assign src_raw[25] = seed_load_strobe;
    // RULE_07: unused codes and software reset
    assign src_raw[29:26] = 4'h0;
    assign src_raw[30] = 1'b0;
    assign src_raw[31] = software_reset_n;

    // Two-stage synchroniser; fast clocks alias, so only slow views are reliable
    always_ff @(posedge clk) begin
        if (srst) begin
            src_meta <= 32'h00000000;
            src_sync <= 32'h00000000;
        end else begin
            src_meta <= src_raw;
            src_sync <= src_meta;
        end
    end

    // Control register write
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= OSR_CTRL_RST;
        end else if (reg_wr_en && reg_wr_addr == OSR_ADDR_CTRL) begin
            ctrl <= reg_wr_data[OSR_CTRL_W-1:0];
        end
    end

    // Source select
    always_comb begin
        next_gpo = 1'b0;
        // RULE_01: route selected source
        unique case (sel)
            // RULE_08: forced value
            OSR_SEL_FORCE: next_gpo = force_val;
            // RULE_03: reserved code
            OSR_SEL_RSV7: next_gpo = 1'b0;
            // RULE_07: buffer enable feeds back
            OSR_SEL_BUF_EN: next_gpo = sdo_oe;
            default: next_gpo = src_sync[sel];
        endcase
        // RULE_07: unused range reads low
        if (sel >= OSR_SEL_UNUSED_LO && sel <= OSR_SEL_UNUSED_HI) begin
            next_gpo = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            gpo_state <= 1'b0;
        end else begin
            gpo_state <= next_gpo;
        end
    end

    // Pin sharing: read data wins, otherwise the selected signal when allowed
    always_comb begin
        // RULE_09: auto sharing gate
        // RULE_10: driver kept on
        next_oe = spi_read_active || keep_driver || !hold_off_auto_lock_mux;
        if (spi_read_active) begin
            next_out = spi_read_data;
        end else if (!hold_off_auto_lock_mux) begin
            next_out = gpo_state;
        end else begin
            next_out = 1'b0;
        end
    end

    // Pin driver flops
    always_ff @(posedge clk) begin
        if (srst) begin
            sdo_out <= 1'b0;
            sdo_oe <= 1'b0;
            sdo_pullup_on <= 1'b0;
            sdo_pulldown_on <= 1'b0;
        end else begin
            sdo_out <= next_out;
            // RULE_15: transistor halves
            sdo_oe <= next_oe && !(pullup_transistor_off && pulldown_transistor_off);
            sdo_pullup_on <= next_oe && !pullup_transistor_off;
            sdo_pulldown_on <= next_oe && !pulldown_transistor_off;
        end
    end

    // Self-test capture
    always_ff @(posedge clk) begin
        if (srst) begin
            sig_q <= 16'h0000;
            busy_q <= 1'b0;
        end else begin
            sig_q <= self_test_signature;
            busy_q <= self_test_running;
        end
    end

    // Read mux; unmapped addresses answer zero
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rd_data <= OSR_RD_RST;
        end else begin
            reg_rd_data <= OSR_RD_RST;
            unique case (reg_rd_addr)
                OSR_ADDR_CTRL: reg_rd_data[OSR_CTRL_W-1:0] <= ctrl;
                // RULE_11: reserved reads zero
                OSR_ADDR_RSV_A, OSR_ADDR_RSV_B: reg_rd_data <= OSR_RD_RST;
                OSR_ADDR_READBACK: begin
                    // RULE_12: state readback
                    reg_rd_data[OSR_RB_GPO_BIT] <= gpo_state;
                    reg_rd_data[OSR_RB_LOCK_BIT] <= src_sync[OSR_SEL_LOCK];
                end
                OSR_ADDR_SELFTEST: begin
                    // RULE_13: signature
                    reg_rd_data[OSR_SIG_W-1:0] <= sig_q;
                    // RULE_14: busy flag
                    reg_rd_data[OSR_ST_BUSY_BIT] <= busy_q;
                end
                default: reg_rd_data <= OSR_RD_RST;
            endcase
        end
    end

    property p_reset_sel;
        @(posedge clk) srst |=> sel == OSR_SEL_LOCK && !force_val;
    endproperty
    a_reset_sel: assert property (p_reset_sel) else $error("select not reset to lock"); // RULE_01

    property p_route;
        @(posedge clk) disable iff (srst)
            (sel != OSR_SEL_FORCE && sel < OSR_SEL_RSV7 && $stable(sel))
            |=> gpo_state == $past(src_sync[sel]);
    endproperty
    a_route: assert property (p_route) else $error("selected source not routed"); // RULE_02

    property p_dup_pullup;
        @(posedge clk) disable iff (srst)
            (sel == 5'h06 && $stable(sel)) |=> gpo_state == $past(src_sync[5]);
    endproperty
    a_dup_pullup: assert property (p_dup_pullup) else $error("code 6 not pull-up"); // RULE_03

    property p_unused;
        @(posedge clk) disable iff (srst)
            (sel inside {[5'h1a:5'h1d], 5'h07}) |=> !gpo_state;
    endproperty
    a_unused: assert property (p_unused) else $error("unused code not low"); // RULE_07

    property p_force;
        @(posedge clk) disable iff (srst)
            (sel == OSR_SEL_FORCE) |=> gpo_state == $past(force_val);
    endproperty
    a_force: assert property (p_force) else $error("forced value not shown"); // RULE_08

    property p_hold_off;
        @(posedge clk) disable iff (srst)
            (hold_off_auto_lock_mux && !spi_read_active && !keep_driver) |=> !sdo_oe;
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("auto sharing not held off"); // RULE_09

    property p_keep;
        @(posedge clk) disable iff (srst)
            (keep_driver && !(pullup_transistor_off && pulldown_transistor_off)) |=> sdo_oe;
    endproperty
    a_keep: assert property (p_keep) else $error("driver turned off"); // RULE_10

    property p_reserved;
        @(posedge clk) disable iff (srst)
            (reg_rd_addr == OSR_ADDR_RSV_A || reg_rd_addr == OSR_ADDR_RSV_B)
            |=> reg_rd_data == OSR_RD_RST;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved read nonzero"); // RULE_11

    property p_readback;
        @(posedge clk) disable iff (srst)
            reg_rd_addr == OSR_ADDR_READBACK
            |=> reg_rd_data[1:0] == {$past(src_sync[1]), $past(gpo_state)};
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch"); // RULE_12

    property p_selftest;
        @(posedge clk) disable iff (srst)
            reg_rd_addr == OSR_ADDR_SELFTEST ##1 reg_rd_addr == OSR_ADDR_SELFTEST
            |=> reg_rd_data[16:0] == {$past(self_test_running, 2), $past(self_test_signature, 2)};
    endproperty
    a_selftest: assert property (p_selftest) else $error("self-test read mismatch"); // RULE_13 RULE_14

    property p_undriven;
        @(posedge clk) disable iff (srst)
            (pullup_transistor_off && pulldown_transistor_off)
            |=> !sdo_oe && !sdo_pullup_on && !sdo_pulldown_on;
    endproperty
    a_undriven: assert property (p_undriven) else $error("pin driven with both halves off"); // RULE_15

    // Upper code groups; sel is stable across the edge, so the past view is the sampled one
    property p_clock_route;
        @(posedge clk) disable iff (srst)
            (sel inside {[5'h08:5'h0c]}) |=> gpo_state == $past(src_sync[sel]);
    endproperty
    a_clock_route: assert property (p_clock_route) else $error("clock code not routed"); // RULE_04

    property p_aux_route;
        @(posedge clk) disable iff (srst)
            (sel inside {[5'h0d:5'h13]}) |=> gpo_state == $past(src_sync[sel]);
    endproperty
    a_aux_route: assert property (p_aux_route) else $error("aux code not routed"); // RULE_05

    property p_strobe_route;
        @(posedge clk) disable iff (srst)
            (sel inside {[5'h14:5'h19]}) |=> gpo_state == $past(src_sync[sel]);
    endproperty
    a_strobe_route: assert property (p_strobe_route) else $error("strobe not routed"); // RULE_06

    property p_buf_en;
        @(posedge clk) disable iff (srst)
            (sel == OSR_SEL_BUF_EN) |=> gpo_state == $past(sdo_oe);
    endproperty
    a_buf_en: assert property (p_buf_en) else $error("buffer enable not shown"); // RULE_07

    property p_soft_rst;
        @(posedge clk) disable iff (srst)
            (sel == OSR_SEL_SOFT_RST) |=> gpo_state == $past(src_sync[OSR_SEL_SOFT_RST]);
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("software reset not shown"); // RULE_07

    // Read data owns the pin whenever the serial interface shifts out and a driver half is on
    property p_read_path;
        @(posedge clk) disable iff (srst)
            (spi_read_active && !(pullup_transistor_off && pulldown_transistor_off))
            |=> sdo_oe && sdo_out == $past(spi_read_data);
    endproperty
    a_read_path: assert property (p_read_path) else $error("read data not on pin"); // RULE_10

    property p_reset_out;
        @(posedge clk) srst |=> reg_rd_data == OSR_RD_RST && !gpo_state && !sdo_oe;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not cleared"); // RULE_12

endmodule

//--- test/osr_host_model.sv
`timescale 1ns/1ps
// Host side of the data out pin: resolves the wire and shifts read bits
module osr_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Pin driver of the device
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic sdo_pullup_on,
    input wire logic sdo_pulldown_on,
    // Read path into the device
    output logic spi_read_active,
    output logic spi_read_data,
    // Wire level and captured byte
    output logic pin_level,
    output logic [7:0] rx_byte
);
    logic last_level = 1'b0;
    logic act_d = 1'b0;
    logic pin_driven;
    // No pull resistor, so a floating wire shows the inverse of its last driven level
    always_comb begin
        pin_driven = sdo_oe && (sdo_out ? sdo_pullup_on : sdo_pulldown_on);
        pin_level = pin_driven ? sdo_out : !last_level;
    end
    // Capture one cycle after each shifted bit, matching the output flop
    always @(posedge clk) begin
        if (pin_driven) begin
            last_level <= pin_level;
        end
        act_d <= spi_read_active && !srst;
        if (srst) begin
            rx_byte <= 8'h00;
        end else if (act_d) begin
            rx_byte <= {rx_byte[6:0], pin_level};
        end
    end
    initial begin
        spi_read_active = 1'b0;
        spi_read_data = 1'b0;
    end
    // Shifts a byte out, most significant bit first
    task automatic shift_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(negedge clk);
            spi_read_active = 1'b1;
            spi_read_data = b[i];
        end
        @(negedge clk);
        spi_read_active = 1'b0;
        spi_read_data = !b[0];
    endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the output select block
module testbench;
    import osr_pkg::*;
    logic clk, srst, reg_wr_en, self_test_running, spi_read_active, spi_read_data;
    logic [5:0] reg_wr_addr, reg_rd_addr;
    logic [23:0] reg_wr_data, reg_rd_data, src;
    logic [15:0] self_test_signature;
    logic sdo_out, sdo_oe, sdo_pullup_on, sdo_pulldown_on, pin_level, exp_bit;
    logic [7:0] rx_byte;
    logic [9:0] drv_cases [3] = '{10'h101, 10'h201, 10'h301};
    logic [2:0] drv_exp [3] = '{3'b011, 3'b101, 3'b000};
    int fails = 0;
    int n_checks = 0;
    // Source per select code: -1 constant low, -2 driver enable, -3 forced bit
    int src_of [32] = '{-3, 0, 1, 2, 3, 4, 4, -1, 5, 6, 7, 8, 9, 10, 11, 12,
        13, 14, 15, 16, 17, 18, 19, 20, 21, 22, -1, -1, -1, -1, -2, 23};

    osr_output_select i_dut (.clk(clk), .srst(srst), .reg_wr_en(reg_wr_en),
        .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data), .spi_read_active(spi_read_active),
        .spi_read_data(spi_read_data), .lock_detect(src[0]), .lock_detect_trigger(src[1]),
        .lock_detect_window(src[2]), .ring_osc_test(src[3]),
        .cycle_slip_guard_pullup(src[4]), .ref_buffer_out(src[5]),
        .ref_divider_out(src[6]), .divider_out(src[7]), .sigma_delta_modulator_clk(src[8]),
        .aux_clk(src[9]), .aux_spi_clk(src[10]), .aux_spi_enable(src[11]),
        .aux_spi_data_out(src[12]), .phase_detector_down_pulse(src[13]),
        .phase_detector_up_pulse(src[14]), .sigma_delta_modulator_clk_delay(src[15]),
        .sigma_delta_modulator_core_clk(src[16]), .auto_strobe_int_write(src[17]),
        .auto_strobe_frac_write(src[18]), .auto_strobe_aux_spi(src[19]),
        .spi_latch_enable(src[20]), .divider_sync_reset(src[21]),
        .seed_load_strobe(src[22]), .software_reset_n(src[23]),
        .self_test_signature(self_test_signature), .self_test_running(self_test_running),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sdo_pullup_on(sdo_pullup_on),
        .sdo_pulldown_on(sdo_pulldown_on));

    osr_host_model i_host (.clk(clk), .srst(srst), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .sdo_pullup_on(sdo_pullup_on), .sdo_pulldown_on(sdo_pulldown_on),
        .spi_read_active(spi_read_active), .spi_read_data(spi_read_data),
        .pin_level(pin_level), .rx_byte(rx_byte));

    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    // Write strobe for one edge, then a quiet cycle before the next access
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        reg_wr_en = 1'b1;
        reg_wr_addr = a;
        reg_wr_data = d;
        @(negedge clk);
        reg_wr_en = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [5:0] a, input logic [23:0] exp);
        reg_rd_addr = a;
        @(negedge clk);
        chk("read data", reg_rd_data, exp);
    endtask
    // Sources pass two sync flops plus two output flops
    task automatic settle;
        repeat (6) @(negedge clk);
    endtask
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = !clk;
    end
    // Watchdog sized well above the expected run
    initial begin
        #20000;
        fails++;
        $display("watchdog expired");
        test_done;
    end
    initial begin
        srst = 1'b1;
        reg_wr_en = 1'b0;
        reg_wr_addr = 6'h00;
        reg_wr_data = 24'h000000;
        reg_rd_addr = 6'h00;
        src = 24'h000000;
        self_test_signature = 16'h0000;
        self_test_running = 1'b0;
        repeat (4) @(negedge clk);
        chk("pin during reset", {20'h0, sdo_out, sdo_oe, sdo_pullup_on, sdo_pulldown_on}, 24'h0);
        srst = 1'b0;
        rd(OSR_ADDR_CTRL, 24'h000001);
        rd(OSR_ADDR_RSV_A, 24'h000000);
        rd(OSR_ADDR_RSV_B, 24'h000000);
        rd(OSR_ADDR_READBACK, 24'h000000);
        rd(OSR_ADDR_SELFTEST, 24'h000000);
        rd(6'h3f, 24'h000000);
        $display("reset test done");
        // Each code twice: selected source low with others high, then inverted
        for (int c = 0; c < 32; c++) begin
            for (int v = 0; v < 2; v++) begin
                exp_bit = (src_of[c] == -2) ? 1'b1 : (src_of[c] == -1) ? 1'b0 : v[0];
                wr(OSR_ADDR_CTRL, {18'h0, v[0], c[4:0]});
                src = (src_of[c] >= 0) ? (24'h1 << src_of[c]) : 24'h0;
                if (v == 0) begin
                    src = ~src;
                end
                settle;
                chk("sdo_out", {23'h0, sdo_out}, {23'h0, exp_bit});
                rd(OSR_ADDR_READBACK, {22'h0, src[0], exp_bit});
            end
        end
        $display("select table test done");
        src = 24'hffffff;
        wr(OSR_ADDR_CTRL, 24'h000041);
        settle;
        chk("mux held off", {22'h0, sdo_out, sdo_oe}, 24'h0);
        // Host in its own serial mode keeps the driver on
        wr(OSR_ADDR_CTRL, 24'h0000c1);
        settle;
        chk("driver kept", {22'h0, sdo_out, sdo_oe}, 24'h1);
        i_host.shift_byte(8'hb4);
        settle;
        chk("read byte", {16'h0, rx_byte}, 24'hb4);
        chk("driver after read", {23'h0, sdo_oe}, 24'h1);
        for (int k = 0; k < 3; k++) begin
            wr(OSR_ADDR_CTRL, {14'h0, drv_cases[k]});
            settle;
            chk("driver halves", {21'h0, sdo_pullup_on, sdo_pulldown_on, sdo_oe},
                {21'h0, drv_exp[k]});
        end
        $display("pin driver test done");
        wr(OSR_ADDR_RSV_A, 24'hffffff);
        rd(OSR_ADDR_RSV_A, 24'h000000);
        rd(OSR_ADDR_CTRL, 24'h000301);
        wr(OSR_ADDR_CTRL, 24'hffffff);
        rd(OSR_ADDR_CTRL, 24'h0003ff);
        self_test_signature = 16'h5a3c;
        self_test_running = 1'b1;
        // Capture flop plus read flop: new inputs show on the second read
        rd(OSR_ADDR_SELFTEST, 24'h000000);
        rd(OSR_ADDR_SELFTEST, 24'h015a3c);
        self_test_running = 1'b0;
        rd(OSR_ADDR_SELFTEST, 24'h015a3c);
        rd(OSR_ADDR_SELFTEST, 24'h005a3c);
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        rd(OSR_ADDR_CTRL, 24'h000001);
        $display("register test done");
        test_done;
    end
endmodule
